// [rtl/brs_pkg.sv]
// Package for the bridge reset sequencer: timing, register layout, states.
// Assumes a 25 MHz system clock shared by both ends.
package brs_pkg;
	localparam int unsigned CLK_HZ            = 25000000;
	// Times as printed, in their own units
	localparam int unsigned LINK_REFERENCE_CLOCK_WAIT_US    = 100;
	localparam int unsigned PWR_WAIT_MS       = 100;
	localparam int unsigned POR_CLK_WAIT_US   = 10;
	localparam int unsigned TRAIN_MAX_MS      = 80;
	// Derived cycle counts: least times round up, longest round down
	localparam int unsigned LINK_REFERENCE_CLOCK_WAIT_CYC   = (LINK_REFERENCE_CLOCK_WAIT_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned PWR_WAIT_CYC      = PWR_WAIT_MS * (CLK_HZ / 1000);
	localparam int unsigned POR_CLK_WAIT_CYC  = (POR_CLK_WAIT_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned TRAIN_MAX_CYC     = TRAIN_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned TRAIN_DELAY_CYC   = 16;
	// Supply sense threshold: 90 percent of nominal
	localparam int unsigned SENSE_W           = 8;
	localparam logic [7:0]  SENSE_NOMINAL     = 8'hff;
	localparam logic [7:0]  SENSE_GOOD        = 8'he6;
	// Secondary bus control register
	localparam logic [7:0]  SEC_BUS_CTL_OFS   = 8'h3e;
	localparam int unsigned SEC_BUS_CTL_W     = 16;
	localparam logic [15:0] SEC_BUS_CTL_RST   = 16'h0000;
	localparam int unsigned SEC_BUS_RESET_BIT = 6;
	localparam int unsigned CFG_W             = 8;
	localparam logic [7:0]  CFG_RST           = 8'h00;

	typedef enum logic [3:0] {
		POR_WAIT_PWR = 4'b0001,
		POR_WAIT_CLK = 4'b0010,
		POR_COUNT    = 4'b0100,
		POR_DONE     = 4'b1000
	} brs_por_type;

	typedef enum logic [4:0] {
		HST_OFF      = 5'b00001,
		HST_PWR      = 5'b00010,
		HST_CLK      = 5'b00100,
		HST_RUN      = 5'b01000,
		HST_DOWN     = 5'b10000
	} brs_host_type;
endpackage

// [rtl/brs_link_if.sv]
// Interface joining the upstream supervisor end and the bridge reset end.
// Assumes both ends share one clock.
interface brs_link_if;
	logic                          fundamental_reset_n;
	logic                          global_power_reset_n;
	logic                          link_reference_clock;
	logic [brs_pkg::SENSE_W-1:0]   core_supply_sense;
	logic                          hot_reset;
	logic                          cfg_wr;
	logic [7:0]                    cfg_addr;
	logic [brs_pkg::SEC_BUS_CTL_W-1:0] cfg_wdata;
	logic [brs_pkg::SEC_BUS_CTL_W-1:0] cfg_rdata;

	modport device (
		input  fundamental_reset_n,
		input  global_power_reset_n,
		input  link_reference_clock,
		input  core_supply_sense,
		input  hot_reset,
		input  cfg_wr,
		input  cfg_addr,
		input  cfg_wdata,
		output cfg_rdata
	);
	modport host (
		output fundamental_reset_n,
		output global_power_reset_n,
		output link_reference_clock,
		output core_supply_sense,
		output hot_reset,
		output cfg_wr,
		output cfg_addr,
		output cfg_wdata,
		input  cfg_rdata
	);
endinterface

// [rtl/brs_device.sv]
// Bridge reset sequencer, device end: power-on reset, reset fan-out, strap capture.
// Assumes link inputs are asynchronous pins; config writes come from the host end.
// Functional notes
// - Host asserts reset, then power, then link_reference_clock
// - Host holds reset 100 us past link_reference_clock
// - Host holds reset 100 ms past power
// - Host powers down: reset, clock, supplies
// - Reset asserted before power or clock lost
// - Hold power-on reset until supply ninety percent
// - Release power-on reset 10 us after clocks
// - Power-on reset initialises every state
// - Bus reset on POR, fundamental or hot
// - Fundamental reset low gives internal link reset
// - Fundamental reset clears non-sticky state
// - Fundamental reset rise means power good
// - Sample static straps on fundamental rise
// - Start EEPROM download if EEPROM present
// - Start link training within 80 ms
// - Hot reset moves link to down state
// - Sticky bits cleared only by global, POR
// - Loadable bits cleared by fundamental, global, POR
// - Control bit 6 drives bus reset
// - Global reset restores all link registers
module brs_device #(
	parameter int unsigned POR_CLK_WAIT = brs_pkg::POR_CLK_WAIT_CYC,
	parameter int unsigned TRAIN_DELAY  = brs_pkg::TRAIN_DELAY_CYC
)(
	input  wire logic                       CLK_SYS,
	input  wire logic                       RST_B,
	brs_link_if.device                      LINK,
	input  wire logic [brs_pkg::CFG_W-1:0]  STRAP_IN,
	input  wire logic                       EEPROM_PRESENT,
	input  wire logic [brs_pkg::CFG_W-1:0]  STICKY_WDATA,
	input  wire logic                       STICKY_WR,
	input  wire logic [brs_pkg::CFG_W-1:0]  LOAD_WDATA,
	input  wire logic                       LOAD_WR,
	output logic                            POR_ACTIVE,
	output logic                            PCI_BUS_RESET,
	output logic                            LINK_RESET,
	output logic                            POWER_GOOD,
	output logic                            EEPROM_START,
	output logic                            TRAIN_START,
	output logic                            LINK_DOWN,
	output logic [brs_pkg::CFG_W-1:0]       STRAP_LATCHED,
	output logic [brs_pkg::CFG_W-1:0]       STICKY_BITS,
	output logic [brs_pkg::CFG_W-1:0]       LOAD_BITS
);
	localparam int unsigned CW = 32;

	// Elaboration check on timing parameters
	if (POR_CLK_WAIT < 1 || TRAIN_DELAY < 1 || TRAIN_DELAY > brs_pkg::TRAIN_MAX_CYC)
		$error("brs_device: bad timing parameters");

	// Two-flop synchronisers for the pins
	logic [1:0]  fundamental_reset_n_sync_ff, global_power_reset_n_sync_ff, clk_sync_ff, hot_sync_ff;
	logic [1:0]  nxt_fundamental_reset_n_sync, nxt_global_power_reset_n_sync, nxt_clk_sync, nxt_hot_sync;
	logic        clk_prev_ff, nxt_clk_prev;
	logic        fundamental_reset_n_prev_ff, nxt_fundamental_reset_n_prev;
	logic [brs_pkg::CFG_W-1:0] strap_s1_ff, strap_s2_ff, nxt_strap_s1, nxt_strap_s2;
	logic [brs_pkg::SENSE_W-1:0] sense_s1_ff, sense_s2_ff, nxt_sense_s1, nxt_sense_s2;
	logic        fundamental_reset_n_n, global_power_reset_n_n, hot_req, clk_edge, fundamental_reset_n_rise;

	always_comb
	begin
		nxt_fundamental_reset_n_sync = {fundamental_reset_n_sync_ff[0], LINK.fundamental_reset_n};
		nxt_global_power_reset_n_sync  = {global_power_reset_n_sync_ff[0], LINK.global_power_reset_n};
		nxt_clk_sync   = {clk_sync_ff[0], LINK.link_reference_clock};
		nxt_hot_sync   = {hot_sync_ff[0], LINK.hot_reset};
		nxt_strap_s1   = STRAP_IN;
		nxt_strap_s2   = strap_s1_ff;
		nxt_sense_s1   = LINK.core_supply_sense;
		nxt_sense_s2   = sense_s1_ff;
		nxt_clk_prev   = clk_sync_ff[1];
		nxt_fundamental_reset_n_prev = fundamental_reset_n_sync_ff[1];
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			fundamental_reset_n_sync_ff <= 2'h0;
			global_power_reset_n_sync_ff  <= 2'h0;
			clk_sync_ff   <= 2'h0;
			hot_sync_ff   <= 2'h0;
			strap_s1_ff   <= brs_pkg::CFG_RST;
			strap_s2_ff   <= brs_pkg::CFG_RST;
			sense_s1_ff   <= '0;
			sense_s2_ff   <= '0;
			clk_prev_ff   <= 1'b0;
			fundamental_reset_n_prev_ff <= 1'b0;
		end
		else
		begin
			fundamental_reset_n_sync_ff <= nxt_fundamental_reset_n_sync;
			global_power_reset_n_sync_ff  <= nxt_global_power_reset_n_sync;
			clk_sync_ff   <= nxt_clk_sync;
			hot_sync_ff   <= nxt_hot_sync;
			strap_s1_ff   <= nxt_strap_s1;
			strap_s2_ff   <= nxt_strap_s2;
			sense_s1_ff   <= nxt_sense_s1;
			sense_s2_ff   <= nxt_sense_s2;
			clk_prev_ff   <= nxt_clk_prev;
			fundamental_reset_n_prev_ff <= nxt_fundamental_reset_n_prev;
		end
	end

	assign fundamental_reset_n_n    = fundamental_reset_n_sync_ff[1];
	assign global_power_reset_n_n     = global_power_reset_n_sync_ff[1];
	assign hot_req    = hot_sync_ff[1];
	assign clk_edge   = clk_sync_ff[1] & ~clk_prev_ff;
	assign fundamental_reset_n_rise = fundamental_reset_n_n & ~fundamental_reset_n_prev_ff;

	// Power-on reset sequencer
	brs_pkg::brs_por_type por_st_ff, nxt_por_st;
	logic [CW-1:0]        por_cnt_ff, nxt_por_cnt;

	always_comb
	begin
		nxt_por_st  = por_st_ff;
		nxt_por_cnt = por_cnt_ff;
		case (por_st_ff)
			brs_pkg::POR_WAIT_PWR:
				if (sense_s2_ff >= brs_pkg::SENSE_GOOD)
					nxt_por_st = brs_pkg::POR_WAIT_CLK;
			brs_pkg::POR_WAIT_CLK:
				if (clk_edge)
				begin
					nxt_por_st  = brs_pkg::POR_COUNT;
					nxt_por_cnt = '0;
				end
			brs_pkg::POR_COUNT:
				if (por_cnt_ff >= POR_CLK_WAIT - 1)
					nxt_por_st = brs_pkg::POR_DONE;
				else
					nxt_por_cnt = por_cnt_ff + 1'b1;
			brs_pkg::POR_DONE:
				nxt_por_st = brs_pkg::POR_DONE;
			default:
				nxt_por_st = brs_pkg::POR_WAIT_PWR;
		endcase
		if (sense_s2_ff < brs_pkg::SENSE_GOOD)
			nxt_por_st = brs_pkg::POR_WAIT_PWR;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			por_st_ff  <= brs_pkg::POR_WAIT_PWR;
			por_cnt_ff <= '0;
		end
		else
		begin
			por_st_ff  <= nxt_por_st;
			por_cnt_ff <= nxt_por_cnt;
		end
	end

	logic por_act, sticky_clr, load_clr, plain_clr;
	assign por_act    = (por_st_ff != brs_pkg::POR_DONE);
	assign sticky_clr = por_act | ~global_power_reset_n_n;
	assign load_clr   = sticky_clr | ~fundamental_reset_n_n;
	assign plain_clr  = load_clr | hot_req;

	// Register state by reset class
	logic [brs_pkg::SEC_BUS_CTL_W-1:0] ctl_ff, nxt_ctl;
	logic [brs_pkg::CFG_W-1:0] sticky_ff, nxt_sticky, load_ff, nxt_load, strap_ff, nxt_strap;
	logic        pwr_good_ff, nxt_pwr_good, eep_ff, nxt_eep, train_ff, nxt_train;
	logic        down_ff, nxt_down, arm_ff, nxt_arm;
	logic [CW-1:0] trn_cnt_ff, nxt_trn_cnt;

	always_comb
	begin
		nxt_ctl      = ctl_ff;
		nxt_sticky   = sticky_ff;
		nxt_load     = load_ff;
		nxt_strap    = strap_ff;
		nxt_pwr_good = pwr_good_ff;
		nxt_eep      = 1'b0;
		nxt_train    = 1'b0;
		nxt_down     = hot_req;
		nxt_arm      = arm_ff;
		nxt_trn_cnt  = trn_cnt_ff;
		if (LINK.cfg_wr && LINK.cfg_addr == brs_pkg::SEC_BUS_CTL_OFS)
			nxt_ctl = LINK.cfg_wdata;
		if (STICKY_WR)
			nxt_sticky = STICKY_WDATA;
		if (LOAD_WR)
			nxt_load = LOAD_WDATA;
		if (fundamental_reset_n_rise && !por_act)
		begin
			nxt_strap    = strap_s2_ff;
			nxt_pwr_good = 1'b1;
			nxt_eep      = EEPROM_PRESENT;
			nxt_arm      = 1'b1;
			nxt_trn_cnt  = '0;
		end
		else if (arm_ff)
		begin
			if (trn_cnt_ff >= TRAIN_DELAY - 1)
			begin
				nxt_train = 1'b1;
				nxt_arm   = 1'b0;
			end
			else
				nxt_trn_cnt = trn_cnt_ff + 1'b1;
		end
		if (plain_clr)
		begin
			nxt_ctl     = brs_pkg::SEC_BUS_CTL_RST;
			nxt_arm     = 1'b0;
			nxt_trn_cnt = '0;
		end
		if (load_clr)
		begin
			nxt_load     = brs_pkg::CFG_RST;
			nxt_pwr_good = 1'b0;
			nxt_eep      = 1'b0;
			nxt_train    = 1'b0;
		end
		if (sticky_clr)
		begin
			nxt_sticky = brs_pkg::CFG_RST;
			nxt_strap  = brs_pkg::CFG_RST;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ctl_ff      <= brs_pkg::SEC_BUS_CTL_RST;
			sticky_ff   <= brs_pkg::CFG_RST;
			load_ff     <= brs_pkg::CFG_RST;
			strap_ff    <= brs_pkg::CFG_RST;
			pwr_good_ff <= 1'b0;
			eep_ff      <= 1'b0;
			train_ff    <= 1'b0;
			down_ff     <= 1'b0;
			arm_ff      <= 1'b0;
			trn_cnt_ff  <= '0;
		end
		else
		begin
			ctl_ff      <= nxt_ctl;
			sticky_ff   <= nxt_sticky;
			load_ff     <= nxt_load;
			strap_ff    <= nxt_strap;
			pwr_good_ff <= nxt_pwr_good;
			eep_ff      <= nxt_eep;
			train_ff    <= nxt_train;
			down_ff     <= nxt_down;
			arm_ff      <= nxt_arm;
			trn_cnt_ff  <= nxt_trn_cnt;
		end
	end

	assign LINK.cfg_rdata = ctl_ff;
	assign POR_ACTIVE     = por_act;
	assign PCI_BUS_RESET  = por_act | ~fundamental_reset_n_n | hot_req
		| ctl_ff[brs_pkg::SEC_BUS_RESET_BIT];
	assign LINK_RESET     = ~fundamental_reset_n_n;
	assign POWER_GOOD     = pwr_good_ff;
	assign EEPROM_START   = eep_ff;
	assign TRAIN_START    = train_ff;
	assign LINK_DOWN      = down_ff;
	assign STRAP_LATCHED  = strap_ff;
	assign STICKY_BITS    = sticky_ff;
	assign LOAD_BITS      = load_ff;
endmodule

// [rtl/brs_host.sv]
// Bridge reset sequencer, supervisor end: orders reset, supply, clock.
// Assumes the same clock as the device end; link_reference_clock is modelled as a divided toggle.
module brs_host #(
	parameter int unsigned LINK_REFERENCE_CLOCK_WAIT = brs_pkg::LINK_REFERENCE_CLOCK_WAIT_CYC,
	parameter int unsigned PWR_WAIT    = brs_pkg::PWR_WAIT_CYC
)(
	input  wire logic                             CLK_SYS,
	input  wire logic                             RST_B,
	brs_link_if.host                              LINK,
	input  wire logic                             POWER_ON,
	input  wire logic                             GLOBAL_RESET,
	input  wire logic                             HOT_RESET,
	input  wire logic                             CFG_WR,
	input  wire logic [7:0]                       CFG_ADDR,
	input  wire logic [brs_pkg::SEC_BUS_CTL_W-1:0] CFG_WDATA,
	output logic [brs_pkg::SEC_BUS_CTL_W-1:0]     CFG_RDATA,
	output logic                                  RUNNING
);
	localparam int unsigned CW = 32;

	// Elaboration check on timing parameters
	if (LINK_REFERENCE_CLOCK_WAIT < 1 || PWR_WAIT < 1)
		$error("brs_host: bad timing parameters");

	brs_pkg::brs_host_type st_ff, nxt_st;
	logic [CW-1:0] pwr_cnt_ff, nxt_pwr_cnt, clk_cnt_ff, nxt_clk_cnt;
	logic          link_reference_clock_ff, nxt_link_reference_clock;
	logic          hot_ff, nxt_hot;

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_pwr_cnt = pwr_cnt_ff;
		nxt_clk_cnt = clk_cnt_ff;
		nxt_hot     = HOT_RESET && st_ff == brs_pkg::HST_RUN;
		nxt_link_reference_clock  = (st_ff == brs_pkg::HST_CLK || st_ff == brs_pkg::HST_RUN) ? ~link_reference_clock_ff : 1'b0;
		case (st_ff)
			brs_pkg::HST_OFF:
				if (POWER_ON)
				begin
					nxt_st      = brs_pkg::HST_PWR;
					nxt_pwr_cnt = '0;
				end
			brs_pkg::HST_PWR:
			begin
				nxt_st      = brs_pkg::HST_CLK;
				nxt_pwr_cnt = pwr_cnt_ff + 1'b1;
				nxt_clk_cnt = '0;
			end
			brs_pkg::HST_CLK:
			begin
				if (pwr_cnt_ff < PWR_WAIT)
					nxt_pwr_cnt = pwr_cnt_ff + 1'b1;
				if (clk_cnt_ff < LINK_REFERENCE_CLOCK_WAIT)
					nxt_clk_cnt = clk_cnt_ff + 1'b1;
				if (pwr_cnt_ff >= PWR_WAIT && clk_cnt_ff >= LINK_REFERENCE_CLOCK_WAIT)
					nxt_st = brs_pkg::HST_RUN;
			end
			brs_pkg::HST_RUN:
				if (!POWER_ON)
				begin
					nxt_st      = brs_pkg::HST_DOWN;
					nxt_clk_cnt = '0;
				end
			// Clock stops a cycle after reset, supply a cycle after that
			brs_pkg::HST_DOWN:
			begin
				nxt_clk_cnt = clk_cnt_ff + 1'b1;
				if (clk_cnt_ff != '0)
					nxt_st = brs_pkg::HST_OFF;
			end
			default:
				nxt_st = brs_pkg::HST_OFF;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_ff      <= brs_pkg::HST_OFF;
			pwr_cnt_ff <= '0;
			clk_cnt_ff <= '0;
			link_reference_clock_ff  <= 1'b0;
			hot_ff     <= 1'b0;
		end
		else
		begin
			st_ff      <= nxt_st;
			pwr_cnt_ff <= nxt_pwr_cnt;
			clk_cnt_ff <= nxt_clk_cnt;
			link_reference_clock_ff  <= nxt_link_reference_clock;
			hot_ff     <= nxt_hot;
		end
	end

	logic powered;
	assign powered                   = (st_ff != brs_pkg::HST_OFF && st_ff != brs_pkg::HST_PWR);
	assign LINK.fundamental_reset_n  = (st_ff == brs_pkg::HST_RUN);
	assign LINK.global_power_reset_n = ~GLOBAL_RESET & powered;
	assign LINK.link_reference_clock = link_reference_clock_ff;
	assign LINK.core_supply_sense    = powered ? brs_pkg::SENSE_NOMINAL : '0;
	assign LINK.hot_reset            = hot_ff;
	assign LINK.cfg_wr               = CFG_WR;
	assign LINK.cfg_addr             = CFG_ADDR;
	assign LINK.cfg_wdata            = CFG_WDATA;
	assign CFG_RDATA                 = LINK.cfg_rdata;
	assign RUNNING                   = (st_ff == brs_pkg::HST_RUN);
endmodule

// [verification/brs_link_chk.sv]
// Concurrent checks on the link between the supervisor end and the bridge end.
// Assumes one clock; the bench instantiates it beside the link interface.
module brs_link_chk #(
	parameter int unsigned LINK_REFERENCE_CLOCK_WAIT = 10,
	parameter int unsigned PWR_WAIT    = 20
)(
	input  wire logic                               CLK_SYS,
	input  wire logic                               RST_B,
	input  wire logic                               fundamental_reset_n,
	input  wire logic                               global_power_reset_n,
	input  wire logic                               link_reference_clock,
	input  wire logic [brs_pkg::SENSE_W-1:0]        core_supply_sense,
	input  wire logic                               hot_reset,
	input  wire logic                               cfg_wr,
	input  wire logic [7:0]                         cfg_addr,
	input  wire logic [brs_pkg::SEC_BUS_CTL_W-1:0]  cfg_wdata,
	input  wire logic [brs_pkg::SEC_BUS_CTL_W-1:0]  cfg_rdata
);
	logic       pwr_on;
	logic       quiet;
	logic       ref_q_ff, nxt_ref_q;
	logic       clk_on_ff, nxt_clk_on;
	logic [9:0] pwr_cnt_ff, nxt_pwr_cnt;
	logic [9:0] clk_cnt_ff, nxt_clk_cnt;
	logic [2:0] quiet_ff, nxt_quiet;

	assign pwr_on = core_supply_sense == brs_pkg::SENSE_NOMINAL;
	assign quiet  = quiet_ff >= 3'h4;

	// Cycles since power, since first clock toggle, since last clear
	always_comb
	begin
		nxt_ref_q   = link_reference_clock;
		nxt_clk_on  = pwr_on && (clk_on_ff || (link_reference_clock != ref_q_ff));
		nxt_pwr_cnt = pwr_on ? pwr_cnt_ff + {9'h000, pwr_cnt_ff != 10'h3ff} : 10'h000;
		nxt_clk_cnt = clk_on_ff ? clk_cnt_ff + {9'h000, clk_cnt_ff != 10'h3ff} : 10'h000;
		nxt_quiet   = quiet_ff + {2'h0, quiet_ff != 3'h7};
		if (!fundamental_reset_n || !global_power_reset_n || hot_reset)
			nxt_quiet = 3'h0;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ref_q_ff   <= 1'b0;
			clk_on_ff  <= 1'b0;
			pwr_cnt_ff <= 10'h000;
			clk_cnt_ff <= 10'h000;
			quiet_ff   <= 3'h0;
		end
		else
		begin
			ref_q_ff   <= nxt_ref_q;
			clk_on_ff  <= nxt_clk_on;
			pwr_cnt_ff <= nxt_pwr_cnt;
			clk_cnt_ff <= nxt_clk_cnt;
			quiet_ff   <= nxt_quiet;
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	sequence s_supply_drop;
		pwr_on ##1 !pwr_on;
	endsequence

	a_release_needs_power: assert property (fundamental_reset_n |-> pwr_on && $changed(link_reference_clock))
		else $error("Reset released without power and running clock");
	a_clock_needs_power: assert property ($rose(link_reference_clock) |-> pwr_on)
		else $error("Reference clock runs without power");
	a_hold_after_clock: assert property ($rose(fundamental_reset_n) |-> clk_cnt_ff >= LINK_REFERENCE_CLOCK_WAIT - 1)
		else $error("Reset released too soon after clock start");
	a_hold_after_power: assert property ($rose(fundamental_reset_n) |-> pwr_cnt_ff >= PWR_WAIT - 1)
		else $error("Reset released too soon after power");
	a_reset_before_off: assert property (s_supply_drop |-> !$past(fundamental_reset_n) && $stable(link_reference_clock))
		else $error("Supply removed before reset and clock stop");
	a_ctl_write_lands: assert property (cfg_wr && cfg_addr == 8'h3e && quiet |=> cfg_rdata == $past(cfg_wdata))
		else $error("Control write not reflected");
	a_other_addr_ignored: assert property (cfg_wr && cfg_addr != 8'h3e && quiet |=> $stable(cfg_rdata))
		else $error("Write to other address changed control");
	a_hot_clears_ctl: assert property (hot_reset [*5] |-> cfg_rdata == 16'h0000)
		else $error("Hot reset left control set");
	a_fund_clears_ctl: assert property (!fundamental_reset_n [*5] |-> cfg_rdata == 16'h0000)
		else $error("Fundamental reset left control set");
	a_global_clears_ctl: assert property (!global_power_reset_n [*5] |-> cfg_rdata == 16'h0000)
		else $error("Global reset left control set");
endmodule

// [verification/bridge_reset_sequencing_tb.sv]
// Self-checking bench: supervisor and bridge ends joined by the link interface.
// Assumes shortened waits; stimulus at rising edges, sampling at falling edges.
module bridge_reset_sequencing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned LINK_REFERENCE_CLOCK_WAIT = 10;
	localparam int unsigned PWR_WAIT    = 20;
	localparam int unsigned TRAIN_DELAY = 16;
	logic        clk_sys = 1'b0;
	logic        rst_b, power_on, glob_rst, hot_rst, cfg_wr, eeprom_present, sticky_wr, load_wr;
	logic [7:0]  cfg_addr, strap_in, sticky_wdata, load_wdata;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic        running, por_active, pci_bus_reset, link_reset, power_good;
	logic        eeprom_start, train_start, link_down;
	logic [7:0]  strap_latched, sticky_bits, load_bits;
	int          err_total = 0;
	int          cmp_count = 0;

	always #20 clk_sys = ~clk_sys;

	brs_link_if i_brs_link_if ();
	brs_host #(.LINK_REFERENCE_CLOCK_WAIT(LINK_REFERENCE_CLOCK_WAIT), .PWR_WAIT(PWR_WAIT)) i_brs_host (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_brs_link_if.host), .POWER_ON(power_on),
		.GLOBAL_RESET(glob_rst), .HOT_RESET(hot_rst), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
		.CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .RUNNING(running));
	brs_device #(.POR_CLK_WAIT(4), .TRAIN_DELAY(TRAIN_DELAY)) i_brs_device (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_brs_link_if.device), .STRAP_IN(strap_in),
		.EEPROM_PRESENT(eeprom_present), .STICKY_WDATA(sticky_wdata), .STICKY_WR(sticky_wr),
		.LOAD_WDATA(load_wdata), .LOAD_WR(load_wr), .POR_ACTIVE(por_active),
		.PCI_BUS_RESET(pci_bus_reset), .LINK_RESET(link_reset), .POWER_GOOD(power_good),
		.EEPROM_START(eeprom_start), .TRAIN_START(train_start), .LINK_DOWN(link_down),
		.STRAP_LATCHED(strap_latched), .STICKY_BITS(sticky_bits), .LOAD_BITS(load_bits));
	brs_link_chk #(.LINK_REFERENCE_CLOCK_WAIT(LINK_REFERENCE_CLOCK_WAIT), .PWR_WAIT(PWR_WAIT)) i_brs_link_chk (
		.CLK_SYS(clk_sys), .RST_B(rst_b),
		.fundamental_reset_n(i_brs_link_if.fundamental_reset_n),
		.global_power_reset_n(i_brs_link_if.global_power_reset_n),
		.link_reference_clock(i_brs_link_if.link_reference_clock),
		.core_supply_sense(i_brs_link_if.core_supply_sense),
		.hot_reset(i_brs_link_if.hot_reset), .cfg_wr(i_brs_link_if.cfg_wr),
		.cfg_addr(i_brs_link_if.cfg_addr), .cfg_wdata(i_brs_link_if.cfg_wdata),
		.cfg_rdata(i_brs_link_if.cfg_rdata));

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_val({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr    <= 1'b0;
		cyc(3);
	endtask

	task automatic group_write(input logic [7:0] s, input logic [7:0] l);
		@(posedge clk_sys);
		sticky_wr    <= 1'b1;
		sticky_wdata <= s;
		load_wr      <= 1'b1;
		load_wdata   <= l;
		@(posedge clk_sys);
		sticky_wr    <= 1'b0;
		load_wr      <= 1'b0;
		cyc(2);
	endtask

	// Power-up through strap capture and training start
	task automatic power_up(input logic [7:0] strap, input logic ee);
		int n;
		@(posedge clk_sys);
		strap_in       <= strap;
		eeprom_present <= ee;
		power_on       <= 1'b1;
		cyc(3);
		check_bit(por_active, 1'b1);
		n = 0;
		while (power_good !== 1'b1 && n < 200)
		begin
			cyc(1);
			n++;
		end
		check_bit(power_good, 1'b1);
		check_bit(running, 1'b1);
		check_bit(por_active, 1'b0);
		check_bit(eeprom_start, ee);
		check_val({8'h00, strap_latched}, {8'h00, strap});
		n = 0;
		while (train_start !== 1'b1 && n < 200)
		begin
			cyc(1);
			n++;
		end
		check_val(16'(n), 16'(TRAIN_DELAY));
		check_bit(link_reset, 1'b0);
		check_bit(pci_bus_reset, 1'b0);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end

	initial
	begin
		{rst_b, power_on, glob_rst, hot_rst, cfg_wr, eeprom_present, sticky_wr, load_wr} = 8'h00;
		{cfg_addr, strap_in, sticky_wdata, load_wdata} = 32'h00000000;
		cfg_wdata = 16'h0000;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		cyc(1);
		check_bit(por_active, 1'b1);
		check_bit(pci_bus_reset, 1'b1);
		check_bit(link_reset, 1'b1);
		check_val(cfg_rdata, 16'h0000);
		power_up(8'h5a, 1'b1);
		@(posedge clk_sys);
		strap_in <= 8'ha5;
		cfg_write(8'h3e, 16'h0040);
		check_val(cfg_rdata, 16'h0040);
		check_bit(pci_bus_reset, 1'b1);
		cfg_write(8'h3e, 16'ha5a5);
		check_val(cfg_rdata, 16'ha5a5);
		check_bit(pci_bus_reset, 1'b0);
		cfg_write(8'h3f, 16'hffff);
		check_val(cfg_rdata, 16'ha5a5);
		check_val({8'h00, strap_latched}, 16'h005a);
		group_write(8'h3c, 8'hc3);
		cfg_write(8'h3e, 16'h0040);
		@(posedge clk_sys);
		hot_rst <= 1'b1;
		cyc(6);
		check_bit(link_down, 1'b1);
		check_bit(pci_bus_reset, 1'b1);
		check_val(cfg_rdata, 16'h0000);
		check_val({sticky_bits, load_bits}, 16'h3cc3);
		@(posedge clk_sys);
		hot_rst <= 1'b0;
		cyc(5);
		check_bit(link_down, 1'b0);
		check_bit(pci_bus_reset, 1'b0);
		cfg_write(8'h3e, 16'h0040);
		check_val(cfg_rdata, 16'h0040);
		@(posedge clk_sys);
		power_on <= 1'b0;
		cyc(8);
		check_bit(running, 1'b0);
		check_val(cfg_rdata, 16'h0000);
		check_bit(link_reset, 1'b1);
		check_bit(pci_bus_reset, 1'b1);
		check_bit(power_good, 1'b0);
		check_bit(por_active, 1'b1);
		check_val({sticky_bits, load_bits}, 16'h0000);
		power_up(8'hc6, 1'b0);
		group_write(8'h3c, 8'hc3);
		cfg_write(8'h3e, 16'h0040);
		check_val({sticky_bits, load_bits}, 16'h3cc3);
		@(posedge clk_sys);
		glob_rst <= 1'b1;
		cyc(6);
		check_val({sticky_bits, load_bits}, 16'h0000);
		check_val(cfg_rdata, 16'h0000);
		@(posedge clk_sys);
		glob_rst <= 1'b0;
		cyc(5);
		wrap_up();
	end
endmodule
